// ==== include/scst_pkg.sv ====
/*
 * Constants shared by the sample clock, SYSREF and over-range logic.
 * Assumes the converter input clock drives sys_clk directly.
 */
package scst_pkg;

   // Divider selection codes: divide by 1, 2, 4 and 8.
   localparam logic [1:0] SEL_DIV1 = 2'h0;
   localparam logic [1:0] SEL_DIV2 = 2'h1;
   localparam logic [1:0] SEL_DIV4 = 2'h2;
   localparam logic [1:0] SEL_DIV8 = 2'h3;

   // Sample rate band in MSPS, for reference by the clock plan.
   localparam int SAMPLE_RATE_MIN_MSPS = 50;
   localparam int SAMPLE_RATE_MAX_MSPS = 370;

   // Over-range assertion delay, 7.5 frame cycles, in input clock cycles
   // rounded up to whole cycles for each divider setting.
   localparam logic [5:0] OVR_DLY_DIV1 = 6'h08;
   localparam logic [5:0] OVR_DLY_DIV2 = 6'h0f;
   localparam logic [5:0] OVR_DLY_DIV4 = 6'h1e;
   localparam logic [5:0] OVR_DLY_DIV8 = 6'h3c;

   // Register stages between a sample and the flag beside the delay line.
   localparam logic [5:0] OVR_PIPE = 6'h02;

   // SYSREF to LMFC delay in input clock cycles (3.5 rounded up to 4).
   localparam logic [4:0] LMFC_DLY_DIV1 = 5'h04;
   localparam logic [4:0] LMFC_DLY_DIV2 = 5'h08;
   localparam logic [4:0] LMFC_DLY_DIV4 = 5'h0f;
   localparam logic [4:0] LMFC_DLY_DIV8 = 5'h1d;

   localparam logic [4:0] LMFC_ONE   = 5'h01;
   localparam logic [3:0] EXTRA_ONE  = 4'h1;
   localparam logic [3:0] DIV_ONE    = 4'h1;
   localparam logic [2:0] CNT_ONE    = 3'h1;

endpackage

// ==== rtl/scst_clock_timing.sv ====
/*
 * Sample clock divider, SYSREF capture with LMFC boundary placement and
 * two over-range flags with programmable release delay.
 * Assumes sys_clk is the undivided converter input clock, the sample
 * flags come from logic on that clock and SYSREF arrives from a pin.
 */
// Operation
// [R1] Sample clock is input clock over divider.
// [R2] Source keeps input clock in divider band.
// [R3] Frame clock period equals sample period.
// [R4] Flag rises 7.5 frames after over-range.
// [R5] Flag falls after assertion plus extra delay.
// [R6] Source holds SYSREF high two frames.
// [R7] Source holds SYSREF low two frames.
// [R8] SYSREF sampled on input clock rising edge.
// [R9] LMFC boundary fixed delay after SYSREF latch.
// [R10] Repeated over-range keeps flag, restarts countdown.
// [R11] Extra release delay is 4-bit field.
`timescale 1ns/10ps

module scst_clock_timing
   import scst_pkg::*;
#(
   parameter int LINE_DEPTH = 64
) (
   input  wire logic       sys_clk,          // Converter input clock.
   input  wire logic       rst_b,            // Asynchronous reset, low.
   input  wire logic [1:0] clockDivideRatio, // Divider select 1/2/4/8.
   input  wire logic [3:0] releaseDelay,     // Extra release frames.
   input  wire logic       sysrefPin,        // SYSREF from the pin.
   input  wire logic       overRangeSampleA, // Channel A sample over range.
   input  wire logic       overRangeSampleB, // Channel B sample over range.
   output logic            frameStrobe,      // One pulse per frame.
   output logic            lmfcBoundary,     // LMFC boundary pulse.
   output logic            overRangeFlagA,   // Channel A over-range flag.
   output logic            overRangeFlagB    // Channel B over-range flag.
);

   // ************************************************************
   // Elaboration check
   // ************************************************************

   // The delay line must reach the longest over-range tap.
   if (LINE_DEPTH < 64)
      $error("LINE_DEPTH too small for the longest over-range delay.");

   // ************************************************************
   // Functions
   // ************************************************************

   // Divide factor for a divider selection.
   function automatic logic [3:0] divFactor(input logic [1:0] sel);
      divFactor = DIV_ONE << sel;
   endfunction

   // Delay line tap giving the over-range assertion delay.
   function automatic logic [5:0] ovrTap(input logic [1:0] sel);
      logic [5:0] dly;
      dly = OVR_DLY_DIV1;
      case (sel)
         SEL_DIV1: dly = OVR_DLY_DIV1;
         SEL_DIV2: dly = OVR_DLY_DIV2;
         SEL_DIV4: dly = OVR_DLY_DIV4;
         default:  dly = OVR_DLY_DIV8;
      endcase
      ovrTap = dly - OVR_PIPE;
   endfunction

   // SYSREF to LMFC delay for a divider selection.
   function automatic logic [4:0] lmfcDelay(input logic [1:0] sel);
      case (sel)
         SEL_DIV1: lmfcDelay = LMFC_DLY_DIV1;
         SEL_DIV2: lmfcDelay = LMFC_DLY_DIV2;
         SEL_DIV4: lmfcDelay = LMFC_DLY_DIV4;
         default:  lmfcDelay = LMFC_DLY_DIV8;
      endcase
   endfunction

   // ************************************************************
   // Sample clock divider
   // ************************************************************

   logic [2:0] divCnt;
   logic [3:0] divNow;
   logic       frameTick;
   logic [2:0] next_divCnt;

   // A frame ends when the counter reaches the divide factor less one.
   assign divNow      = divFactor(clockDivideRatio);
   assign frameTick   = ({1'b0, divCnt} >= (divNow - DIV_ONE)); // R1
   assign next_divCnt = frameTick ? 3'h0 : divCnt + CNT_ONE;

   // Divider counter and registered frame strobe.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         divCnt      <= 3'h0;
         frameStrobe <= 1'b0;
      end else begin
         divCnt      <= next_divCnt;
         frameStrobe <= frameTick; // R3
      end
   end

   // ************************************************************
   // SYSREF capture and LMFC boundary
   // ************************************************************

   logic       sysrefSync1;
   logic       sysrefSync2;
   logic       sysrefSync3;
   logic       sysrefLevel;
   logic       sysrefRise;
   logic [4:0] lmfcCnt;

   // A rise counts once the second and third stages agree and go high.
   assign sysrefRise = sysrefSync2 && sysrefSync3 && !sysrefLevel;

   // Three stage synchroniser, sampled on the rising input clock edge.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sysrefSync1 <= 1'b0;
         sysrefSync2 <= 1'b0;
         sysrefSync3 <= 1'b0;
         sysrefLevel <= 1'b0;
      end else begin
         sysrefSync1 <= sysrefPin; // R8
         sysrefSync2 <= sysrefSync1;
         sysrefSync3 <= sysrefSync2;
         if (sysrefSync2 == sysrefSync3) begin
            sysrefLevel <= sysrefSync3; // R8
         end
      end
   end

   // Countdown from the latched SYSREF edge to the boundary pulse.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lmfcCnt      <= 5'h00;
         lmfcBoundary <= 1'b0;
      end else begin
         lmfcBoundary <= (lmfcCnt == LMFC_ONE); // R9
         if (sysrefRise) begin
            lmfcCnt <= lmfcDelay(clockDivideRatio) - LMFC_ONE; // R9
         end else if (lmfcCnt != 5'h00) begin
            lmfcCnt <= lmfcCnt - LMFC_ONE;
         end
      end
   end

   // ************************************************************
   // Over-range flags
   // ************************************************************

   logic [LINE_DEPTH-1:0] tickLine;
   logic [LINE_DEPTH-1:0] ovrLineA;
   logic [LINE_DEPTH-1:0] ovrLineB;
   logic [5:0]            tapIdx;
   logic                  tapTick;
   logic [1:0]            tapOvr;
   logic [1:0]            flag;
   logic [3:0]            extraCnt [2];

   // Taps give each sample and its tick at the assertion delay.
   assign tapIdx  = ovrTap(clockDivideRatio);
   assign tapTick = tickLine[tapIdx];
   assign tapOvr  = {ovrLineB[tapIdx], ovrLineA[tapIdx]};
   assign overRangeFlagA = flag[0];
   assign overRangeFlagB = flag[1];

   // Delay lines carry sampled frames and their over-range state.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tickLine <= '0;
         ovrLineA <= '0;
         ovrLineB <= '0;
      end else begin
         tickLine <= {tickLine[LINE_DEPTH-2:0], frameTick};
         ovrLineA <= {ovrLineA[LINE_DEPTH-2:0], frameTick && overRangeSampleA};
         ovrLineB <= {ovrLineB[LINE_DEPTH-2:0], frameTick && overRangeSampleB};
      end
   end

   // Each flag sets on a delayed over-range and counts out its release.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag     <= 2'h0;
         extraCnt <= '{4'h0, 4'h0};
      end else begin
         for (int ch = 0; ch < 2; ch++) begin
            if (tapTick && tapOvr[ch]) begin
               flag[ch]     <= 1'b1;         // R4
               extraCnt[ch] <= releaseDelay; // R10 R11
            end else if (tapTick && flag[ch]) begin
               if (extraCnt[ch] == 4'h0) begin
                  flag[ch] <= 1'b0; // R5
               end else begin
                  extraCnt[ch] <= extraCnt[ch] - EXTRA_ONE; // R5
               end
            end
         end
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************

   property p_div4_period;
      @(posedge sys_clk) disable iff (!rst_b)
      (frameTick && clockDivideRatio == SEL_DIV4 && $stable(clockDivideRatio))
         |=> (!frameTick)[*3] ##1 frameTick;
   endproperty
   a_div4_period: assert property (p_div4_period) // R1
      else $error("Divide-by-4 frame period wrong.");

   property p_frame_div8;
      @(posedge sys_clk) disable iff (!rst_b)
      (frameStrobe && clockDivideRatio == SEL_DIV8 && $stable(clockDivideRatio))
         |=> (!frameStrobe)[*7] ##1 frameStrobe;
   endproperty
   a_frame_div8: assert property (p_frame_div8) // R3
      else $error("Frame strobe period wrong at divide-by-8.");

   property p_ovr_assert;
      @(posedge sys_clk) disable iff (!rst_b)
      (clockDivideRatio == SEL_DIV1 && frameTick && overRangeSampleA)
         |-> ##8 overRangeFlagA;
   endproperty
   a_ovr_assert: assert property (p_ovr_assert) // R4
      else $error("Over-range flag A late.");

   property p_ovr_release;
      @(posedge sys_clk) disable iff (!rst_b)
      (clockDivideRatio == SEL_DIV1 && releaseDelay == 4'h0 &&
       $past(overRangeSampleB) && !overRangeSampleB)
         |-> ##8 !overRangeFlagB;
   endproperty
   a_ovr_release: assert property (p_ovr_release) // R5
      else $error("Over-range flag B not released.");

   property p_ovr_restart;
      @(posedge sys_clk) disable iff (!rst_b)
      (tapTick && tapOvr[0])
         |=> overRangeFlagA && extraCnt[0] == $past(releaseDelay);
   endproperty
   a_ovr_restart: assert property (p_ovr_restart) // R10
      else $error("Release countdown not restarted.");

   property p_extra_count;
      @(posedge sys_clk) disable iff (!rst_b)
      (tapTick && !tapOvr[1] && flag[1] && extraCnt[1] != 4'h0)
         |=> flag[1] && extraCnt[1] == $past(extraCnt[1]) - EXTRA_ONE;
   endproperty
   a_extra_count: assert property (p_extra_count) // R11
      else $error("Extra release delay miscounted.");

   property p_sysref_agree;
      @(posedge sys_clk) disable iff (!rst_b)
      (sysrefLevel != $past(sysrefLevel))
         |-> $past(sysrefSync2) == $past(sysrefSync3);
   endproperty
   a_sysref_agree: assert property (p_sysref_agree) // R8
      else $error("SYSREF level changed without agreement.");

   property p_lmfc_div2;
      @(posedge sys_clk) disable iff (!rst_b)
      (sysrefRise && clockDivideRatio == SEL_DIV2)
         |-> (!lmfcBoundary)[*8] ##1 lmfcBoundary;
   endproperty
   a_lmfc_div2: assert property (p_lmfc_div2) // R9
      else $error("LMFC boundary early after SYSREF.");

   property p_lmfc_hit;
      @(posedge sys_clk) disable iff (!rst_b)
      (sysrefRise && clockDivideRatio == SEL_DIV2) |-> ##8 lmfcBoundary;
   endproperty
   a_lmfc_hit: assert property (p_lmfc_hit) // R9
      else $error("LMFC boundary missing after SYSREF.");

endmodule

// ==== verification/scst_sysref_src.sv ====
/* SYSREF source model for the clock timing bench.
   Assumes the bench clocks it and asks for each pulse with fire. */
`timescale 1ns/10ps
module scst_sysref_src (
   input  wire logic       sys_clk,  // Converter input clock.
   input  wire logic       fire,     // Request for one pulse.
   input  wire logic [3:0] frameLen, // Input clocks per frame.
   output logic            sysrefPin // SYSREF towards the device.
);
   // One pulse, then a quiet gap, each two frames long.
   initial begin
      sysrefPin = 1'b0;
      forever begin
         @(posedge sys_clk);
         if (fire === 1'b1) begin
            #1 sysrefPin = 1'b1;
            repeat (2 * frameLen) @(posedge sys_clk);
            #1 sysrefPin = 1'b0;
            repeat (2 * frameLen) @(posedge sys_clk);
         end
      end
   end
endmodule

// ==== verification/scst_clock_timing_tb_top.sv ====
/* Self-checking bench for the sample clock, SYSREF and over-range block.
   Assumes the SYSREF source model and the design package are compiled. */
`timescale 1ns/10ps
module scst_clock_timing_tb_top;
   import scst_pkg::*;
   typedef struct packed {
      logic [1:0] sel;
      logic [3:0] rel;
      logic [7:0] div;
      logic [7:0] ovr;
      logic [7:0] lmfc;
   } scst_row_t;
   // Divider code, extra delay, then frame, flag and boundary delays.
   scst_row_t  rows [4] = '{'{SEL_DIV1, 4'h0, 8'h01, 8'h08, 8'h04},
                            '{SEL_DIV2, 4'hf, 8'h02, 8'h0f, 8'h08},
                            '{SEL_DIV4, 4'h3, 8'h04, 8'h1e, 8'h0f},
                            '{SEL_DIV8, 4'h1, 8'h08, 8'h3c, 8'h1d}};
   logic       sys_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [1:0] ratio = SEL_DIV1;
   logic [3:0] relDly = 4'h0;
   logic [3:0] frameLen = 4'h1;
   logic       fire = 1'b0;
   logic       smpA = 1'b1;
   logic       smpB = 1'b1;
   logic       sysrefPin, strobe, lmfc, flagA, flagB;
   int         badCount, nTests, cycles, rA, fA, rB, fB, n;

   scst_clock_timing #(.LINE_DEPTH(64)) DUT (.sys_clk(sys_clk),
      .rst_b(rst_b), .clockDivideRatio(ratio), .releaseDelay(relDly),
      .sysrefPin(sysrefPin), .overRangeSampleA(smpA),
      .overRangeSampleB(smpB), .frameStrobe(strobe), .lmfcBoundary(lmfc),
      .overRangeFlagA(flagA), .overRangeFlagB(flagB));
   scst_sysref_src SRC (.sys_clk(sys_clk), .fire(fire),
      .frameLen(frameLen), .sysrefPin(sysrefPin));

   // Clock and a cycle ceiling that cuts a hang short.
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         badCount++;
         endSim();
      end
   end

   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic check(input logic [31:0] seen, exp, input string msg);
      nTests++;
      if (seen !== exp) begin
         badCount++;
         $display("unexpected at %0t: %s %0d not %0d", $time, msg, seen, exp);
      end
   endtask

   // Plays one bit per frame from each pattern, from the next frame on,
   // and notes when each flag first rises and then falls.
   task automatic ovrRun(input logic [31:0] pa, pb, input int div, lim);
      {rA, fA, rB, fB} = '0;
      n = 0;
      while (strobe !== 1'b1) step();
      while (n < lim) begin
         if (n % div == 0) begin
            smpA = pa[0];
            smpB = pb[0];
            pa = pa >> 1;
            pb = pb >> 1;
         end
         step();
         n++;
         if (flagA === 1'b1 && rA == 0) rA = n;
         if (flagA !== 1'b1 && rA != 0 && fA == 0) fA = n;
         if (flagB === 1'b1 && rB == 0) rB = n;
         if (flagB !== 1'b1 && rB != 0 && fB == 0) fB = n;
      end
   endtask

   task automatic endSim();
      $display("comparisons %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (8) step();
      rst_b = 1'b1;
      smpA = 1'b0;
      smpB = 1'b0;
      foreach (rows[i]) begin
         // The divider is changed under reset so the frame phase restarts.
         rst_b = 1'b0;
         ratio = rows[i].sel;
         relDly = rows[i].rel;
         frameLen = rows[i].div[3:0];
         step();
         rst_b = 1'b1;
         repeat (20) step();
         while (strobe !== 1'b1) step();
         n = 0;
         do begin
            step();
            n++;
         end while (strobe !== 1'b1 && n < 20);
         check(n, rows[i].div, "frame spacing");
         ovrRun(32'h1, 32'h3, rows[i].div,
                4 * rows[i].div + rows[i].ovr + rows[i].div * rows[i].rel + 8);
         // The flag stands the delay after the cycle that holds the tick.
         check(rA, rows[i].div + rows[i].ovr - 1, "flag rise");
         check(fA - rA, rows[i].div * (1 + rows[i].rel), "A high");
         check(fB - rB, rows[i].div * (2 + rows[i].rel), "B high");
         fire = 1'b1;
         step();
         fire = 1'b0;
         n = 0;
         do begin
            step();
            n++;
         end while (lmfc !== 1'b1 && n < 60);
         check(n, rows[i].lmfc + 3, "boundary delay");
         step();
         check(lmfc, 1'b0, "boundary width");
         repeat (4 * rows[i].div) step();
         $display("divider row %0d done", i);
      end
      // Reset in mid-run with both channels over range.
      smpA = 1'b1;
      smpB = 1'b1;
      rst_b = 1'b0;
      repeat (8) step();
      check({strobe, lmfc, flagA, flagB}, 4'h0, "outputs in reset");
      ratio = SEL_DIV1;
      relDly = 4'h8;
      smpA = 1'b0;
      smpB = 1'b0;
      rst_b = 1'b1;
      step();
      // At divide-by-1 the first edge after release already ends a frame.
      check({strobe, lmfc, flagA, flagB}, 4'h8, "outputs after reset");
      $display("reset test done");
      // A second over-range in mid-countdown must keep the flag up.
      ovrRun(32'h21, 32'h0, 1, 40);
      check(rA, 8, "restart rise");
      check(fA - rA, 14, "restart high");
      check(rB, 0, "quiet channel");
      $display("restart test done");
      endSim();
   end
endmodule
